// *** design/acs_top.sv ***
`timescale 1ns/1ps
`include "acs_defs.svh"
// Contract
// - aes source on optical 2 feeds that spdif into aes channel, drops xlr
// - auto madi input activates whichever input first carries valid madi
// - split madi input receives both ports, 32 channels each
// - record processing puts input eq and dynamics in the record path
// - with loopback, record uses output channel eq and dynamics instead
// - optical 1 carries 15-22 multichannel or 15/16 spdif
// - optical 2 carries 23-30 multichannel or 23/24 spdif
// - optical 2 set to aes transmits the aes output as spdif
// - madi mirror drives coaxial output with same stream as optical
// - split madi output sends 32 channels on each port
// - above 48 kHz madi output uses 48k or native 96k frame
// - word, aes, optical inputs report no lock, lock, sync and frequency
// - each madi input reports lock, rate, frame type, channel count
// - single speed folds word clock output into 32 to 48 kHz
// - without single speed, base-rate word clock locks higher internal rate
// - with single speed, internal rate follows external word clock fully
// - keep preferred input while valid, else first valid input in order from word clock
// - no valid input runs internal master and shows current source; code does this only with auto set, else keeps preferred source as slave
// - reference failure in auto mode falls back to internal clock
// - count and report usb transmission errors
// - 88.2/96 double, 176.4/192 quad speed, channels halved or quartered
module acs_top
  import acs_pkg::*;
#(
  parameter int CRC_W = 16
) (
  // clock and reset
  input  logic              clock,
  input  logic              srst,
  // axi4-lite register slave
  input  logic [7:0]        s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [7:0]        s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  // receiver status pins: word, aes, optical 1, optical 2
  input  acs_in_s   [3:0]   in_st,
  input  acs_madi_s [1:0]   madi_st,
  input  logic              usb_crc_err,
  // routing and clocking controls
  output acs_route_s        route,
  output acs_clk_s          clk_ctl
);
  if (CRC_W < 1 || CRC_W > 32) begin : g_chk
    $error("CRC_W must be 1 to 32");
  end

  localparam int SW = 4 * 6 + 2 * 8 + 1;

  logic [SW-1:0]      meta_ff;
  logic [SW-1:0]      sync_ff;
  logic               crc_d_ff;
  acs_in_s   [3:0]    ins;
  acs_madi_s [1:0]    mds;
  logic               crc_lvl;
  logic [5:0]         valid;
  logic [5:0]         syn;
  logic [5:0][3:0]    frq;
  logic [31:0]        ctrl_ff;
  acs_route_s         route_ff;
  acs_route_s         nxt_route;
  acs_clk_s           clk_ff;
  acs_clk_s           nxt_clk;
  acs_ma_e            ma_ff;
  acs_ma_e            nxt_ma;
  logic [CRC_W-1:0]   crc_ff;
  logic               crc_evt;
  logic               crc_clr;
  logic [7:0]         aw_ff;
  logic               aw_v_ff;
  logic [31:0]        w_ff;
  logic [3:0]         ws_ff;
  logic               w_v_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [31:0]        rdata_ff;
  logic [1:0]         rresp_ff;
  logic               do_wr;
  logic               do_rd;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic [11:0]        lkst;
  acs_src_e           pref;
  acs_min_e           min_mode;
  acs_mout_e          mout_mode;
  logic [3:0]         rate_sel;
  logic [1:0]         spd_i;

  // rate code helpers: speed class and base family
  function automatic logic [1:0] spd(input logic [3:0] c);
    spd = (c > 4'h6) ? 2'h2 : (c > 4'h3) ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [1:0] fam(input logic [3:0] c);
    logic [3:0] t;
    t = 4'(c - 4'h1 - {1'b0, spd(c), 1'b0} - {2'h0, spd(c)});
    fam = (c == `ACS_RATE_NONE) ? 2'h0 : t[1:0];
  endfunction
  function automatic logic [3:0] mk(input logic [1:0] f, input logic [1:0] s);
    mk = 4'(4'h1 + {2'h0, f} + {1'b0, s, 1'b0} + {2'h0, s});
  endfunction

  // two-stage synchroniser for all pin status
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_ff  <= '0;
      sync_ff  <= '0;
      crc_d_ff <= 1'b0;
    end else begin
      meta_ff  <= {in_st, madi_st, usb_crc_err};
      sync_ff  <= meta_ff;
      crc_d_ff <= crc_lvl;
    end
  end
  assign {ins, mds, crc_lvl} = sync_ff;

  // per-input valid, sync and frequency views
  for (genvar i = 0; i < 6; i++) begin : g_in
    if (i < 4) begin : g_d
      assign valid[i] = ins[i].lock | ins[i].sync;
      assign syn[i]   = ins[i].sync;
      assign frq[i]   = ins[i].freq;
    end else begin : g_m
      assign valid[i] = mds[i-4].lock | mds[i-4].sync;
      assign syn[i]   = mds[i-4].sync;
      assign frq[i]   = mds[i-4].freq;
    end
    assign lkst[2*i +: 2] = {syn[i], valid[i] & ~syn[i]};
  end

  // control field views
  assign pref      = acs_src_e'(ctrl_ff[`ACS_F_SRC]);
  assign min_mode  = acs_min_e'(ctrl_ff[`ACS_F_MADIIN]);
  assign mout_mode = acs_mout_e'(ctrl_ff[`ACS_F_MADIOUT]);
  assign rate_sel  = ctrl_ff[`ACS_F_RATE];
  assign spd_i     = spd(clk_ff.int_rate);

  // reference selection and internal rate
  always_comb begin
    logic [3:0] ext;
    ext         = `ACS_RATE_NONE;
    nxt_clk     = '0;
    nxt_clk.src = ACS_SRC_INT;
    if (pref != ACS_SRC_INT && pref != ACS_SRC_RSVD) begin
      if (!ctrl_ff[`ACS_F_AUTO] || valid[pref - 3'h1]) begin
        nxt_clk.src = pref;
      end else begin
        for (int i = 5; i >= 0; i--) begin
          if (valid[i]) nxt_clk.src = acs_src_e'(3'(i + 1));
        end
      end
    end
    nxt_clk.master = (nxt_clk.src == ACS_SRC_INT);
    ext = (nxt_clk.master) ? `ACS_RATE_NONE : frq[nxt_clk.src - 3'h1];
    if (ext == `ACS_RATE_NONE) nxt_clk.int_rate = rate_sel;
    else if (nxt_clk.src == ACS_SRC_WORD && !ctrl_ff[`ACS_F_SSPEED])
      nxt_clk.int_rate = mk(fam(ext), spd(rate_sel));
    else nxt_clk.int_rate = ext;
    nxt_clk.wc_out_rate = ctrl_ff[`ACS_F_SSPEED] ?
      mk(fam(nxt_clk.int_rate), 2'h0) : nxt_clk.int_rate;
  end

  // automatic madi input choice
  always_comb begin
    nxt_ma = ma_ff;
    case (ma_ff)
      ACS_MA_SCAN: begin
        if (valid[4]) nxt_ma = ACS_MA_OPT;
        else if (valid[5]) nxt_ma = ACS_MA_COAX;
      end
      ACS_MA_OPT:  if (!valid[4]) nxt_ma = ACS_MA_SCAN;
      ACS_MA_COAX: if (!valid[5]) nxt_ma = ACS_MA_SCAN;
      default:     nxt_ma = ACS_MA_SCAN;
    endcase
    if (min_mode != ACS_MI_AUTO) nxt_ma = ACS_MA_SCAN;
  end

  always_ff @(posedge clock) begin
    if (srst) ma_ff <= ACS_MA_SCAN;
    else ma_ff <= nxt_ma;
  end

  // port routing from control and current speed
  always_comb begin
    nxt_route = '0;
    nxt_route.aes_in_opt2 = ctrl_ff[`ACS_F_AESOPT2];
    case (min_mode)
      ACS_MI_OPT:   nxt_route.madi_rx_opt = 1'b1;
      ACS_MI_COAX:  nxt_route.madi_rx_coax = 1'b1;
      ACS_MI_AUTO: begin
        nxt_route.madi_rx_opt  = (ma_ff == ACS_MA_OPT);
        nxt_route.madi_rx_coax = (ma_ff == ACS_MA_COAX);
      end
      default: begin
        nxt_route.madi_rx_opt  = 1'b1;
        nxt_route.madi_rx_coax = 1'b1;
      end
    endcase
    nxt_route.madi_rx_ch = (min_mode == ACS_MI_SPLIT) ?
      (`ACS_MADI_SPLIT >> spd_i) : (`ACS_MADI_CH64 >> spd_i);
    nxt_route.rec_eq_in  = ctrl_ff[`ACS_F_RECPROC] & ~ctrl_ff[`ACS_F_LOOPBK];
    nxt_route.rec_eq_out = ctrl_ff[`ACS_F_RECPROC] & ctrl_ff[`ACS_F_LOOPBK];
    nxt_route.opt1_spdif = ctrl_ff[`ACS_F_OPT1SP];
    nxt_route.opt1_first = `ACS_OPT1_FIRST;
    nxt_route.opt1_ch    = ctrl_ff[`ACS_F_OPT1SP] ?
      `ACS_SPDIF_CH : (`ACS_OPT_CH >> spd_i);
    nxt_route.opt2_spdif = (ctrl_ff[`ACS_F_OPT2] != 2'h0);
    nxt_route.opt2_aes   = (ctrl_ff[`ACS_F_OPT2] == 2'h2);
    nxt_route.opt2_first = `ACS_OPT2_FIRST;
    nxt_route.opt2_ch    = nxt_route.opt2_spdif ?
      `ACS_SPDIF_CH : (`ACS_OPT_CH >> spd_i);
    nxt_route.wc_out_madi  = (mout_mode == ACS_MO_MIRROR);
    nxt_route.madi_tx_coax = (mout_mode == ACS_MO_MIRROR) ||
                             (mout_mode == ACS_MO_SPLIT);
    if (mout_mode == ACS_MO_SPLIT) nxt_route.madi_tx_ch = `ACS_MADI_SPLIT >> spd_i;
    else if (ctrl_ff[`ACS_F_FMT56]) nxt_route.madi_tx_ch = `ACS_MADI_CH56 >> spd_i;
    else nxt_route.madi_tx_ch = `ACS_MADI_CH64 >> spd_i;
    nxt_route.madi_tx_f96 = ctrl_ff[`ACS_F_FRAME96] & (spd_i != 2'h0);
  end

  // registered routing and clock outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      route_ff <= '0;
      clk_ff   <= '{src: ACS_SRC_INT, master: 1'b1, default: '0};
    end else begin
      route_ff <= nxt_route;
      clk_ff   <= nxt_clk;
    end
  end
  assign route   = route_ff;
  assign clk_ctl = clk_ff;

  // usb error counter, a same-cycle clear and event leave a count of one
  assign crc_evt = crc_lvl & ~crc_d_ff;
  assign crc_clr = do_wr && (aw_ff == `ACS_REG_CRC);
  always_ff @(posedge clock) begin
    if (srst) crc_ff <= '0;
    else if (crc_evt && crc_clr) crc_ff <= CRC_W'(1);
    else if (crc_clr) crc_ff <= '0;
    else if (crc_evt && crc_ff != '1) crc_ff <= crc_ff + CRC_W'(1);
  end

  // axi write address and data capture, any order
  assign s_axi_awready = ~aw_v_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_v_ff & ~bvalid_ff;
  assign do_wr         = aw_v_ff & w_v_ff & ~bvalid_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_v_ff <= 1'b0;
      w_v_ff  <= 1'b0;
      aw_ff   <= '0;
      w_ff    <= '0;
      ws_ff   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_v_ff <= 1'b1;
        aw_ff   <= s_axi_awaddr;
      end else if (do_wr) aw_v_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_v_ff <= 1'b1;
        w_ff   <= s_axi_wdata;
        ws_ff  <= s_axi_wstrb;
      end else if (do_wr) w_v_ff <= 1'b0;
    end
  end

  // write response and control register update
  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `ACS_RESP_OK;
      ctrl_ff   <= `ACS_CTRL_RST;
    end else begin
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (aw_ff == `ACS_REG_CTRL || aw_ff == `ACS_REG_CRC) ?
                     `ACS_RESP_OK : `ACS_RESP_ERR;
        if (aw_ff == `ACS_REG_CTRL) begin
          for (int b = 0; b < 4; b++) begin
            if (ws_ff[b]) ctrl_ff[8*b +: 8] <= w_ff[8*b +: 8];
          end
        end
      end else if (s_axi_bready) bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // read decode
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `ACS_REG_CTRL: rd_data = ctrl_ff;
      `ACS_REG_STAT: begin
        rd_data[2:0]  = clk_ff.src;
        rd_data[3]    = clk_ff.master;
        rd_data[4]    = route_ff.madi_rx_opt;
        rd_data[5]    = route_ff.madi_rx_coax;
        rd_data[17:6] = lkst;
      end
      `ACS_REG_FREQ: rd_data[27:0] = {clk_ff.int_rate, frq};
      `ACS_REG_MADI: rd_data[11:0] = {clk_ff.wc_out_rate, 4'h0,
        mds[1].ch64, mds[1].frame96, mds[0].ch64, mds[0].frame96};
      `ACS_REG_CRC:  rd_data[CRC_W-1:0] = crc_ff;
      default:       rd_ok = 1'b0;
    endcase
  end

  // read channel
  assign s_axi_arready = ~rvalid_ff;
  assign do_rd         = s_axi_arvalid & ~rvalid_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= `ACS_RESP_OK;
    end else if (do_rd) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_data;
      rresp_ff  <= rd_ok ? `ACS_RESP_OK : `ACS_RESP_ERR;
    end else if (s_axi_rready) rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_aes_held;
    ctrl_ff[`ACS_F_AESOPT2] [*2];
  endsequence
  AST_AES_ROUTE: assert property (s_aes_held |-> route_ff.aes_in_opt2)
    else $error("aes input not taken from optical 2");

  sequence s_auto_opt_seen;
    min_mode == ACS_MI_AUTO && ma_ff == ACS_MA_SCAN && valid[4];
  endsequence
  AST_MADI_AUTO: assert property (s_auto_opt_seen ##1 min_mode == ACS_MI_AUTO
    |-> ##1 route_ff.madi_rx_opt && !route_ff.madi_rx_coax)
    else $error("auto madi input did not activate optical");

  AST_SPLIT_RX: assert property ($past(min_mode) == ACS_MI_SPLIT
    |-> route_ff.madi_rx_opt && route_ff.madi_rx_coax)
    else $error("split madi input not on both ports");

  AST_REC_PATH: assert property ($past(ctrl_ff[`ACS_F_RECPROC] && ctrl_ff[`ACS_F_LOOPBK])
    |-> route_ff.rec_eq_out && !route_ff.rec_eq_in)
    else $error("loopback record not taken through output processing");

  AST_OPT1_CH: assert property (route_ff.opt1_spdif |-> route_ff.opt1_ch == 4'h2)
    else $error("optical 1 spdif channel count wrong");

  AST_MIRROR: assert property ($past(mout_mode) == ACS_MO_MIRROR
    |-> route_ff.wc_out_madi && route_ff.madi_tx_coax)
    else $error("mirror without coaxial madi output");

  sequence s_all_lost;
    ctrl_ff[`ACS_F_AUTO] && valid == 6'h00 [*2];
  endsequence
  AST_FALLBACK: assert property (s_all_lost |-> clk_ff.master
    && clk_ff.src == ACS_SRC_INT)
    else $error("no fallback to internal clock");

  AST_PREF: assert property (ctrl_ff[`ACS_F_AUTO] && pref == ACS_SRC_AES
    && valid[1] ##1 $stable(ctrl_ff) && valid[1] |-> clk_ff.src == ACS_SRC_AES)
    else $error("valid preferred input not kept");

  sequence s_crc_evt;
    crc_evt && !crc_clr && crc_ff < CRC_W'(8);
  endsequence
  AST_CRC_CNT: assert property (s_crc_evt |=> crc_ff == $past(crc_ff) + CRC_W'(1))
    else $error("usb error not counted");
endmodule

// *** design/acs_defs.svh ***
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// register byte offsets
`define ACS_REG_CTRL   8'h00
`define ACS_REG_STAT   8'h04
`define ACS_REG_FREQ   8'h08
`define ACS_REG_MADI   8'h0C
`define ACS_REG_CRC    8'h10
`define ACS_CTRL_RST   32'h0006_0008
// control field positions
`define ACS_F_SRC      2:0
`define ACS_F_AUTO     3
`define ACS_F_SSPEED   4
`define ACS_F_AESOPT2  5
`define ACS_F_MADIIN   7:6
`define ACS_F_RECPROC  8
`define ACS_F_LOOPBK   9
`define ACS_F_OPT1SP   10
`define ACS_F_OPT2     12:11
`define ACS_F_MADIOUT  14:13
`define ACS_F_FMT56    15
`define ACS_F_FRAME96  16
`define ACS_F_RATE     20:17
// channel figures
`define ACS_OPT1_FIRST 5'h0F
`define ACS_OPT2_FIRST 5'h17
`define ACS_OPT_CH     4'h8
`define ACS_SPDIF_CH   4'h2
`define ACS_MADI_CH64  7'h40
`define ACS_MADI_CH56  7'h38
`define ACS_MADI_SPLIT 7'h20
// rate codes: 1..9 = 32,44.1,48,64,88.2,96,128,176.4,192 kHz
`define ACS_RATE_NONE  4'h0
`define ACS_RESP_OK    2'h0
`define ACS_RESP_ERR   2'h2
`endif

// *** design/acs_pkg.sv ***
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_SRC_INT, ACS_SRC_WORD, ACS_SRC_AES, ACS_SRC_OPT1,
    ACS_SRC_OPT2, ACS_SRC_MADI_O, ACS_SRC_MADI_C, ACS_SRC_RSVD
  } acs_src_e;
  typedef enum logic [1:0] {ACS_MI_OPT, ACS_MI_COAX, ACS_MI_AUTO, ACS_MI_SPLIT} acs_min_e;
  typedef enum logic [1:0] {ACS_MO_OPT, ACS_MO_MIRROR, ACS_MO_SPLIT, ACS_MO_RSVD} acs_mout_e;
  typedef enum {ACS_MA_SCAN, ACS_MA_OPT, ACS_MA_COAX} acs_ma_e;
  typedef struct packed {logic lock; logic sync; logic [3:0] freq;} acs_in_s;
  typedef struct packed {
    logic lock; logic sync; logic [3:0] freq; logic frame96; logic ch64;
  } acs_madi_s;
  typedef struct packed {
    logic       aes_in_opt2;
    logic       madi_rx_opt;
    logic       madi_rx_coax;
    logic [6:0] madi_rx_ch;
    logic       rec_eq_in;
    logic       rec_eq_out;
    logic       opt1_spdif;
    logic [4:0] opt1_first;
    logic [3:0] opt1_ch;
    logic       opt2_spdif;
    logic       opt2_aes;
    logic [4:0] opt2_first;
    logic [3:0] opt2_ch;
    logic       madi_tx_coax;
    logic       wc_out_madi;
    logic [6:0] madi_tx_ch;
    logic       madi_tx_f96;
  } acs_route_s;
  typedef struct packed {
    acs_src_e   src;
    logic       master;
    logic [3:0] int_rate;
    logic [3:0] wc_out_rate;
  } acs_clk_s;
endpackage

// *** design/acs_pkg_unused_guard.sv ***
`timescale 1ns/1ps

// *** test/acs_src_model.sv ***
`timescale 1ns/1ps
// behavioural far side: external digital sources feeding the status pins
module acs_src_model
  import acs_pkg::*;
(
  // clock
  input  logic             clock,
  // requested states: 0..3 serial inputs, 4 madi optical, 5 madi coaxial
  input  logic [5:0]       lock_q,
  input  logic [5:0]       sync_q,
  input  logic [3:0]       freq_q,
  input  logic [1:0]       f96_q,
  input  logic [1:0]       c64_q,
  input  logic             err_q,
  // pins toward the device
  output acs_in_s   [3:0]  in_st,
  output acs_madi_s [1:0]  madi_st,
  output logic             usb_crc_err
);
  // sources are clock slaves: sync is only claimed while locked
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      in_st[i] <= lock_q[i] ? {1'b1, sync_q[i], freq_q} : 6'h00;
    end
    for (int m = 0; m < 2; m++) begin
      madi_st[m] <= lock_q[4+m] ? {1'b1, sync_q[4+m], freq_q, f96_q[m], c64_q[m]} : 8'h00;
    end
    usb_crc_err <= err_q;
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "acs_defs.svh"
// self-checking bench for the clock source selector
module tb
  import acs_pkg::*;
;
  logic            clock;
  logic            srst;
  logic [7:0]      awaddr;
  logic            awvalid;
  logic            awready;
  logic [31:0]     wdata;
  logic            wvalid;
  logic            wready;
  logic [1:0]      bresp;
  logic            bvalid;
  logic            bready;
  logic [7:0]      araddr;
  logic            arvalid;
  logic            arready;
  logic [31:0]     rdata;
  logic [1:0]      rresp;
  logic            rvalid;
  logic            rready;
  logic [5:0]      lock_q;
  logic [5:0]      sync_q;
  logic [3:0]      freq_q;
  logic            err_q;
  acs_in_s   [3:0] in_st;
  acs_madi_s [1:0] madi_st;
  logic            usb_crc_err;
  acs_route_s      route;
  acs_clk_s        clk_ctl;
  int              failures = 0;
  int              checks = 0;
  logic [31:0]     rd_v;
  logic [1:0]      rsp;

  acs_top #(.CRC_W(16)) u_dut (
    .clock(clock), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_st(in_st), .madi_st(madi_st), .usb_crc_err(usb_crc_err),
    .route(route), .clk_ctl(clk_ctl)
  );

  acs_src_model u_src (
    .clock(clock), .lock_q(lock_q), .sync_q(sync_q), .freq_q(freq_q),
    .f96_q(2'b01), .c64_q(2'b01), .err_q(err_q),
    .in_st(in_st), .madi_st(madi_st), .usb_crc_err(usb_crc_err)
  );

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // axi4-lite write: handshakes sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah;
    logic wh;
    logic bh;
    bh = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  // axi4-lite read
  task automatic rd(input logic [7:0] a);
    logic ah;
    logic rh;
    rh = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge clock);
      ah = arvalid && arready;
      rh = (rvalid === 1'b1);
      rd_v = rdata;
      rsp = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // let pipelines settle, then look just after the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // write the control word and wait for the routing outputs
  task automatic cfg(input logic [31:0] d);
    wr(`ACS_REG_CTRL, d);
    settle(3);
  endtask

  // change what the far side presents, wait through the synchronisers
  task automatic src(input logic [5:0] l, input logic [5:0] s, input logic [3:0] f);
    @(posedge clock);
    lock_q <= l;
    sync_q <= s;
    freq_q <= f;
    settle(6);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, err_q} = '0;
    {lock_q, sync_q, freq_q} = '0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    // reset state and unmapped address
    rd(`ACS_REG_CTRL);
    chk(rd_v, `ACS_CTRL_RST);
    settle(0);
    chk(32'({clk_ctl.src, clk_ctl.master}), 32'({ACS_SRC_INT, 1'b1}));
    wr(8'h14, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(`ACS_RESP_ERR));
    rd(8'h14);
    chk(rd_v, 32'h0);
    chk(32'(rsp), 32'(`ACS_RESP_ERR));
    // aes from optical 2, split madi in/out, record processing, spdif optics
    cfg(32'h0006_55E0);
    chk(32'(route.aes_in_opt2), 32'h1);
    chk(32'({route.madi_rx_opt, route.madi_rx_coax, route.madi_rx_ch}), 32'h1A0);
    chk(32'({route.rec_eq_in, route.rec_eq_out}), 32'h2);
    chk(32'({route.opt1_spdif, route.opt1_first, route.opt1_ch}), 32'h2F2);
    chk(32'(route.opt2_aes), 32'h1);
    chk(32'({route.madi_tx_coax, route.madi_tx_ch}), 32'hA0);
    // auto madi input, loopback, mirror, 56 channels, 96k frame bit ignored at 48k
    cfg(32'h0007_AB80);
    src(6'b10_0000, 6'h00, 4'h3);
    src(6'b11_0000, 6'h00, 4'h3);
    chk(32'({route.madi_rx_opt, route.madi_rx_coax}), 32'h1);
    src(6'b01_0000, 6'h00, 4'h3);
    chk(32'({route.madi_rx_opt, route.madi_rx_coax}), 32'h2);
    chk(32'({route.rec_eq_in, route.rec_eq_out}), 32'h1);
    chk(32'({route.opt2_spdif, route.opt2_first, route.opt2_ch}), 32'h372);
    chk(32'({route.opt1_first, route.opt1_ch}), 32'hF8);
    chk(32'({route.wc_out_madi, route.madi_tx_f96, route.madi_tx_ch}), 32'h138);
    // same at 96 kHz: native frame, halved channel counts
    cfg(32'h000D_AB80);
    chk(32'({route.madi_tx_f96, route.madi_tx_ch, route.opt1_ch}), 32'h9C4);
    chk(32'(clk_ctl.int_rate), 32'h6);
    // preferred aes with fallback, then loss of inputs in turn
    cfg(32'h0006_000A);
    chk(32'({route.opt2_spdif, route.opt2_ch, route.madi_rx_opt, route.madi_rx_coax}), 32'h22);
    src(6'b00_0011, 6'h00, 4'h3);
    chk(32'({clk_ctl.src, clk_ctl.master}), 32'({ACS_SRC_AES, 1'b0}));
    chk(32'(route.madi_tx_ch), 32'(`ACS_MADI_CH64));
    src(6'b10_1001, 6'h00, 4'h3);
    chk(32'(clk_ctl.src), 32'(ACS_SRC_WORD));
    src(6'b10_1000, 6'h00, 4'h3);
    chk(32'(clk_ctl.src), 32'(ACS_SRC_OPT2));
    src(6'b10_0000, 6'h00, 4'h3);
    chk(32'(clk_ctl.src), 32'(ACS_SRC_MADI_C));
    src(6'h00, 6'h00, 4'h3);
    chk(32'({clk_ctl.src, clk_ctl.master}), 32'({ACS_SRC_INT, 1'b1}));
    rd(`ACS_REG_STAT);
    chk(32'(rd_v[3:0]), 32'h8);
    // input status: word sync, aes lock, madi optical lock
    src(6'b01_0011, 6'b00_0001, 4'h3);
    rd(`ACS_REG_STAT);
    chk(32'(rd_v[9:6]), 32'h6);
    chk(32'(rd_v[15:14]), 32'h1);
    rd(`ACS_REG_FREQ);
    chk(32'(rd_v[7:0]), 32'h33);
    rd(`ACS_REG_MADI);
    chk(32'(rd_v[3:0]), 32'h3);
    // word clock as reference, then single speed following 192 kHz
    cfg(32'h000C_0041);
    src(6'b00_0001, 6'b00_0001, 4'h3);
    chk(32'({route.madi_rx_opt, route.madi_rx_coax}), 32'h1);
    chk(32'({clk_ctl.int_rate, clk_ctl.wc_out_rate}), 32'h66);
    cfg(32'h000C_0011);
    src(6'b00_0001, 6'b00_0001, 4'h9);
    chk(32'({clk_ctl.int_rate, clk_ctl.wc_out_rate}), 32'h93);
    rd(`ACS_REG_MADI);
    chk(32'(rd_v[11:8]), 32'h3);
    // three usb link errors, then clear
    repeat (6) begin
      @(posedge clock);
      err_q <= ~err_q;
      repeat (2) @(posedge clock);
    end
    settle(6);
    rd(`ACS_REG_CRC);
    chk(rd_v, 32'h3);
    wr(`ACS_REG_CRC, 32'h0);
    rd(`ACS_REG_CRC);
    chk(rd_v, 32'h0);
    stop_test();
  end
endmodule
